//--- copwd_defines.svh
`ifndef COPWD_DEFINES_SVH
`define COPWD_DEFINES_SVH

// register byte offsets
`define COPWD_OFS_CONTROL    8'h00
`define COPWD_OFS_SERVICE    8'h04
`define COPWD_OFS_STATUS     8'h08
`define COPWD_OFS_MASK       8'h0c
`define COPWD_OFS_COUNT      8'h10
`define COPWD_OFS_FLAGS      8'h14

// control field positions
`define COPWD_CLKSEL_HI      7
`define COPWD_CLKSEL_LO      6
`define COPWD_DBG_BIT        5
`define COPWD_STOP_BIT       4
`define COPWD_TSEL_HI        3
`define COPWD_TSEL_LO        2
`define COPWD_LONG_BIT       1
`define COPWD_WIN_BIT        0

`define COPWD_CONTROL_RESET  8'h00
`define COPWD_STATUS_RESET   3'h0
`define COPWD_MASK_RESET     3'h0

// status bit positions
`define COPWD_ST_EXPIRE      0
`define COPWD_ST_BADVAL      1
`define COPWD_ST_EARLY       2

// service sequence bytes
`define COPWD_SVC_FIRST      8'h55
`define COPWD_SVC_SECOND     8'haa

// timeout exponents, short and long
`define COPWD_SHORT_EXP1     5
`define COPWD_SHORT_EXP2     8
`define COPWD_SHORT_EXP3     10
`define COPWD_LONG_EXP1      13
`define COPWD_LONG_EXP2      16
`define COPWD_LONG_EXP3      18

`endif

//--- copwd_pkg.sv
package copwd_pkg;

  typedef enum logic [1:0]
  {
    COPWD_SRC_LPO,
    COPWD_SRC_IREF,
    COPWD_SRC_EXT,
    COPWD_SRC_BUS
  } copwd_src_e;

  typedef enum logic [1:0]
  {
    COPWD_TO_OFF,
    COPWD_TO_1,
    COPWD_TO_2,
    COPWD_TO_3
  } copwd_tsel_e;

  typedef logic [17:0] copwd_cnt_t;

endpackage

//--- copwd_tick.sv
`timescale 1ns/1ps
// turns a slow clock level into one-cycle count ticks on its rising edge
module copwd_tick
  import copwd_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic level,
  output logic      tick
);

  logic level_q;

  always_ff @(posedge clk)
  begin
    if (reset)
      level_q <= 1'b1; // a source high at release is no edge
    else
      level_q <= level;
  end

  assign tick = level & ~level_q;

endmodule

//--- copwd_top.sv
`timescale 1ns/1ps
`include "copwd_defines.svh"

module copwd_top
  import copwd_pkg::*;
#(
  parameter int LONG_EXP1 = `COPWD_LONG_EXP1,
  parameter int LONG_EXP2 = `COPWD_LONG_EXP2,
  parameter int LONG_EXP3 = `COPWD_LONG_EXP3
)
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        debug_mode,
  input  wire logic        stop_mode,
  input  wire logic        low_power_osc_clock,
  input  wire logic        internal_reference_clock,
  input  wire logic        external_osc_clock,
  output logic             system_reset_req,
  output logic             irq
);

  logic [7:0]  control_q;
  logic        locked_q;
  copwd_cnt_t  count_q;
  logic        armed_q;
  logic        reset_req_q;
  logic [2:0]  status_q;
  logic [2:0]  mask_q;
  logic        rd_done_q;
  logic [31:0] rdata_q;

  copwd_src_e  wdog_clock_source;
  logic        wdog_run_in_debug;
  logic        wdog_run_in_stop;
  copwd_tsel_e wdog_timeout_select;
  logic        wdog_long_timeout;
  logic        wdog_windowed;

  logic        tick_lpo;
  logic        tick_iref;
  logic        tick_ext;
  logic        tick;
  logic        enabled;
  logic        running;
  logic        window_mode;
  int          exp_sel;
  logic [18:0] limit;
  copwd_cnt_t  last_count;
  copwd_cnt_t  window_start;
  logic        window_open;
  logic        expire;

  logic        wr_ctl;
  logic        wr_svc;
  logic        wr_mask;
  logic        rd_fire;
  logic        rd_status;
  logic [7:0]  svc_val;
  logic        svc_first;
  logic        svc_second;
  logic        svc_bad;
  logic        svc_early;
  logic        svc_ok;
  logic [2:0]  events;

  // field views of the control register
  assign wdog_clock_source =
    copwd_src_e'(control_q[`COPWD_CLKSEL_HI:`COPWD_CLKSEL_LO]);
  assign wdog_run_in_debug   = control_q[`COPWD_DBG_BIT];
  assign wdog_run_in_stop    = control_q[`COPWD_STOP_BIT];
  assign wdog_timeout_select =
    copwd_tsel_e'(control_q[`COPWD_TSEL_HI:`COPWD_TSEL_LO]);
  assign wdog_long_timeout   = control_q[`COPWD_LONG_BIT];
  assign wdog_windowed       = control_q[`COPWD_WIN_BIT];

  // bus access decode
  assign wr_ctl  = avs_write && (avs_address == `COPWD_OFS_CONTROL);
  assign wr_svc  = avs_write && (avs_address == `COPWD_OFS_SERVICE)
                   && avs_byteenable[0];
  assign wr_mask = avs_write && (avs_address == `COPWD_OFS_MASK)
                   && avs_byteenable[0];
  // reads take one wait state so read data come from a register
  assign rd_fire   = avs_read && rd_done_q;
  assign rd_status = rd_fire && (avs_address == `COPWD_OFS_STATUS);
  assign avs_waitrequest = avs_read && !rd_done_q;
  assign avs_readdata    = rdata_q;

  // slow clock sources, sampled as synchronous levels
  copwd_tick u_tick_lpo
  (
    .clk   (clk),
    .reset (reset),
    .level (low_power_osc_clock),
    .tick  (tick_lpo)
  );

  copwd_tick u_tick_iref
  (
    .clk   (clk),
    .reset (reset),
    .level (internal_reference_clock),
    .tick  (tick_iref)
  );

  copwd_tick u_tick_ext
  (
    .clk   (clk),
    .reset (reset),
    .level (external_osc_clock),
    .tick  (tick_ext)
  );

  always_comb
  begin
    case (wdog_clock_source)
      COPWD_SRC_LPO:  tick = tick_lpo;
      COPWD_SRC_IREF: tick = tick_iref;
      COPWD_SRC_EXT:  tick = tick_ext;
      default:        tick = 1'b1;
    endcase
  end

  // timeout length from the select and length fields
  always_comb
  begin
    case (wdog_timeout_select)
      COPWD_TO_1:
        exp_sel = wdog_long_timeout ? LONG_EXP1 : `COPWD_SHORT_EXP1;
      COPWD_TO_2:
        exp_sel = wdog_long_timeout ? LONG_EXP2 : `COPWD_SHORT_EXP2;
      COPWD_TO_3:
        exp_sel = wdog_long_timeout ? LONG_EXP3 : `COPWD_SHORT_EXP3;
      default:
        exp_sel = `COPWD_SHORT_EXP1;
    endcase
  end

  assign limit        = 19'h00001 << exp_sel[4:0];
  assign last_count   = 18'(limit - 19'h00001);
  // window opens three quarters into the period
  assign window_start = 18'(limit - (limit >> 2));

  assign enabled = (wdog_timeout_select != COPWD_TO_OFF);
  assign running = enabled
                   && !(debug_mode && !wdog_run_in_debug)
                   && !(stop_mode && !wdog_run_in_stop);
  // windowing is ignored unless the long timeout is in use
  assign window_mode = wdog_windowed && wdog_long_timeout;
  assign window_open = count_q >= window_start;

  assign expire = running && tick && (count_q == last_count);

  // service sequence decode
  assign svc_val    = avs_writedata[7:0];
  assign svc_first  = wr_svc && running
                      && (svc_val == `COPWD_SVC_FIRST);
  assign svc_second = wr_svc && running && armed_q
                      && (svc_val == `COPWD_SVC_SECOND);
  assign svc_bad    = wr_svc && running
                      && !svc_first && !svc_second;
  assign svc_early  = svc_second && window_mode && !window_open;
  assign svc_ok     = svc_second && !svc_early;

  assign events[`COPWD_ST_EXPIRE] = expire;
  assign events[`COPWD_ST_BADVAL] = svc_bad;
  assign events[`COPWD_ST_EARLY]  = svc_early;

  // write-once control register
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      control_q <= `COPWD_CONTROL_RESET;
      locked_q  <= 1'b0;
    end
    else if (wr_ctl && !locked_q)
    begin
      // any first write locks, even one without the low byte lane
      locked_q <= 1'b1;
      if (avs_byteenable[0])
        control_q <= avs_writedata[7:0];
    end
  end

  // timeout counter
  always_ff @(posedge clk)
  begin
    if (reset)
      count_q <= '0;
    else if (wr_ctl)
      count_q <= '0;
    else if (!running)
      count_q <= '0;
    else if (svc_ok || expire)
      count_q <= '0;
    else if (tick)
      count_q <= count_q + 18'h00001;
  end

  // first half of the service sequence
  always_ff @(posedge clk)
  begin
    if (reset)
      armed_q <= 1'b0;
    else if (!running)
      armed_q <= 1'b0;
    else if (wr_svc)
      armed_q <= svc_first;
  end

  // held until the system reset comes back around to clear it
  always_ff @(posedge clk)
  begin
    if (reset)
      reset_req_q <= 1'b0;
    else if (expire || svc_bad || svc_early)
      reset_req_q <= 1'b1;
  end

  assign system_reset_req = reset_req_q;

  // sticky status; a read clears only the bits it returned, new ones stay
  always_ff @(posedge clk)
  begin
    if (reset)
      status_q <= `COPWD_STATUS_RESET;
    else if (rd_status)
      status_q <= (status_q & ~rdata_q[2:0]) | events;
    else
      status_q <= status_q | events;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      mask_q <= `COPWD_MASK_RESET;
    else if (wr_mask)
      mask_q <= avs_writedata[2:0];
  end

  assign irq = |(status_q & mask_q);

  // read path
  always_ff @(posedge clk)
  begin
    if (reset)
      rd_done_q <= 1'b0;
    else
      rd_done_q <= avs_read && !rd_done_q;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      rdata_q <= '0;
    else if (avs_read && !rd_done_q)
    begin
      if (avs_address == `COPWD_OFS_CONTROL)
        rdata_q <= {24'h000000, control_q};
      else if (avs_address == `COPWD_OFS_STATUS)
        rdata_q <= {29'h00000000, status_q};
      else if (avs_address == `COPWD_OFS_MASK)
        rdata_q <= {29'h00000000, mask_q};
      else if (avs_address == `COPWD_OFS_COUNT)
        rdata_q <= {14'h0000, count_q};
      else if (avs_address == `COPWD_OFS_FLAGS)
        rdata_q <= {27'h0000000, window_open, armed_q, running,
                    enabled, locked_q};
      else
        // service register is write only; unmapped reads give zero
        rdata_q <= '0;
    end
  end

endmodule

//--- copwd_monitor.sv
`timescale 1ns/1ps
module copwd_monitor
  import copwd_pkg::*;
#(
  parameter int LONG_EXP1 = 13,
  parameter int LONG_EXP2 = 16,
  parameter int LONG_EXP3 = 18
)
(
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        debug_mode,
  input wire logic        stop_mode,
  input wire logic        system_reset_req
);
  logic [7:0]  cfg_q;
  logic        lock_q;
  logic        svc_q;
  logic [19:0] since_q;
  int          lim;
  wire ctl_wr = avs_write && avs_address == 8'h00;
  wire svc_wr = avs_write && avs_address == 8'h04;
  wire rd_end = avs_read && !avs_waitrequest && avs_address == 8'h00;
  wire held = (debug_mode && !cfg_q[5]) || (stop_mode && !cfg_q[4]);
  wire run = cfg_q[3:2] != 2'h0 && !held;
  wire [7:0] wb = avs_writedata[7:0];

  function automatic int span(logic [7:0] c);
    int e;
    case (c[3:2])
      2'h1: e = c[1] ? LONG_EXP1 : 5;
      2'h2: e = c[1] ? LONG_EXP2 : 8;
      default: e = c[1] ? LONG_EXP3 : 10;
    endcase
    return 1 << e;
  endfunction
  assign lim = span(cfg_q);

  // first write since reset is the only one that counts
  always_ff @(posedge clk)
    if (reset)
    begin
      lock_q <= 1'b0;
      cfg_q  <= 8'h00;
    end
    else if (ctl_wr && !lock_q)
    begin
      lock_q <= 1'b1;
      if (avs_byteenable[0])
        cfg_q <= wb;
    end

  // cycles since the count was last cleared; services spoil the figure
  always_ff @(posedge clk)
  begin
    if (reset || ctl_wr || held)
      since_q <= 20'h00000;
    else if (since_q != 20'hfffff)
      since_q <= since_q + 20'h00001;
    if (reset || ctl_wr)
      svc_q <= 1'b0;
    else if (svc_wr)
      svc_q <= 1'b1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_first_wins: assert property (
    rd_end |-> avs_readdata[7:0] == cfg_q)
    else $error("control read differs from first write");
  a_high_zero: assert property (
    rd_end |-> avs_readdata[31:8] == 24'h0)
    else $error("control upper bits not zero");
  a_off_quiet: assert property (
    cfg_q[3:2] == 2'h0 |-> !system_reset_req)
    else $error("reset request while disabled");
  a_expiry_time: assert property (
    $rose(system_reset_req) && cfg_q[7:6] == 2'h3 && !svc_q
    |-> since_q >= lim - 1 && since_q <= lim + 3)
    else $error("expiry at wrong cycle");
  a_bad_service: assert property (
    svc_wr && run && avs_byteenable[0] && wb != 8'h55 && wb != 8'haa
    |-> ##[1:2] system_reset_req)
    else $error("bad service value ignored");
  a_held_quiet: assert property (
    held [*4] |-> !$rose(system_reset_req))
    else $error("expiry while held");
  a_req_sticky: assert property (
    system_reset_req |=> system_reset_req)
    else $error("reset request dropped");
  a_req_clear: assert property (
    disable iff (1'b0) reset |=> !system_reset_req)
    else $error("reset request survives reset");
endmodule

//--- copwd_top_test.sv
`timescale 1ns/1ps
module copwd_top_test;
  import copwd_pkg::*;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        debug_mode = 1'b0;
  logic        stop_mode = 1'b0;
  logic        low_power_osc_clock = 1'b0;
  logic        internal_reference_clock = 1'b0;
  logic        external_osc_clock = 1'b0;
  logic        system_reset_req;
  logic        irq;
  logic [31:0] rv;
  int          num_errors = 0;
  int          n_checks = 0;
  int          ph = 0;
  // slow sources at 8, 6 and 10 clk periods so each is told apart
  logic [7:0]  xc [9] = '{8'hc5, 8'hc8, 8'hcc, 8'hc6, 8'hca, 8'hce,
                          8'h04, 8'h44, 8'h84};
  int          xt [9] = '{32, 256, 1024, 512, 1024, 2048, 256, 192, 320};
  logic [7:0]  mc [5] = '{8'h00, 8'hc4, 8'he4, 8'hc4, 8'hd4};
  logic [2:0]  mf [5] = '{3'h0, 3'h2, 3'h6, 3'h1, 3'h5};

  copwd_top #(.LONG_EXP1(9), .LONG_EXP2(10), .LONG_EXP3(11)) copwd_top_inst
  (.clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
   .avs_byteenable, .avs_readdata, .avs_waitrequest, .debug_mode,
   .stop_mode, .low_power_osc_clock, .internal_reference_clock,
   .external_osc_clock, .system_reset_req, .irq);

  initial
    forever #50 clk = ~clk;

  always @(posedge clk)
  begin
    ph <= ph + 1;
    low_power_osc_clock <= (ph % 8) < 4;
    internal_reference_clock <= (ph % 6) < 3;
    external_osc_clock <= (ph % 10) < 5;
  end

  task automatic conclude;
    if (num_errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %s expected %h got %h", nm, e, g);
    end
  endtask

  task automatic chk_rng(string nm, int lo, int hi, int g);
    n_checks++;
    if (g < lo || g > hi)
    begin
      num_errors++;
      $display("BAD %s expected %0d..%0d got %0d", nm, lo, hi, g);
    end
  endtask

  // request held until waitrequest is seen low at a rising edge;
  // read data taken at that edge, one idle edge before the next request
  task automatic acc(logic w, logic [7:0] a, logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk);
    rv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdc(logic [7:0] a, logic [31:0] e, string nm);
    acc(1'b0, a, 32'h0);
    chk(nm, e, rv);
  endtask

  task automatic svc;
    acc(1'b1, 8'h04, 32'h55);
    acc(1'b1, 8'h04, 32'haa);
  endtask

  task automatic restart(logic d, logic s);
    reset <= 1'b1;
    debug_mode <= d;
    stop_mode <= s;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
  endtask

  task automatic poll(int lim, output int n);
    n = 0;
    while (system_reset_req !== 1'b1 && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    // back on the rising edge so the next request starts there
    @(posedge clk);
  endtask

  initial
  begin
    int n;
    int t;
    restart(1'b0, 1'b0);
    rdc(8'h00, 32'h0, "control_reset");
    rdc(8'h20, 32'h0, "unmapped");
    acc(1'b1, 8'h00, 32'hffffffc5);
    repeat (20) @(posedge clk);
    acc(1'b1, 8'h00, 32'h0);
    // without the clear the 32-cycle period would run out inside this poll
    poll(20, n);
    chk("cleared_count", 0, system_reset_req);
    repeat (6)
    begin
      svc();
      repeat (15) @(posedge clk);
    end
    rdc(8'h00, 32'hc5, "control_locked");
    chk("serviced", 0, system_reset_req);
    acc(1'b1, 8'h04, 32'h12);
    poll(4, n);
    chk("bad_service", 1, system_reset_req);
    rdc(8'h08, 32'h2, "bad_status");
    restart(1'b0, 1'b0);
    acc(1'b1, 8'h00, 32'hc7);
    repeat (420) @(posedge clk);
    svc();
    chk("late_service", 0, system_reset_req);
    repeat (100) @(posedge clk);
    svc();
    poll(4, n);
    chk("early_service", 1, system_reset_req);
    rdc(8'h08, 32'h4, "early_status");
    for (int i = 0; i < 5; i++)
    begin
      restart(mf[i][1], mf[i][0]);
      acc(1'b1, 8'h00, {24'h0, mc[i]});
      poll(100, n);
      chk("hold_mode", mf[i][2], system_reset_req);
    end
    for (int i = 0; i < 9; i++)
    begin
      t = i < 6 ? 3 : 12;
      restart(1'b0, 1'b0);
      if (i == 0)
      begin
        acc(1'b1, 8'h0c, 32'h1);
        rdc(8'h0c, 32'h1, "mask_readback");
      end
      acc(1'b1, 8'h00, {24'h0, xc[i]});
      poll(xt[i] + t + 4, n);
      chk_rng("expiry_cycles", xt[i] - t, xt[i] + t, n);
      chk("expire_req", 1, system_reset_req);
      chk("irq", i == 0, irq);
      if (i == 0)
      begin
        rdc(8'h08, 32'h1, "expire_status");
        chk("irq_clear", 0, irq);
      end
    end
    conclude();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    conclude();
  end
endmodule

bind copwd_top copwd_monitor #(.LONG_EXP1(LONG_EXP1),
  .LONG_EXP2(LONG_EXP2), .LONG_EXP3(LONG_EXP3)) copwd_monitor_inst
  (.clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
   .avs_byteenable, .avs_readdata, .avs_waitrequest, .debug_mode,
   .stop_mode, .system_reset_req);
